// >>> pse_defs.svh
// constants for the scratch and power event register block
// Behaviour
// (RQ1) 8-bit scratch register, offset 0x16, resets zero
// (RQ2) scratch value drives no other logic
// (RQ3) link never writes ones to bits 7,1
// (RQ4) bit 6 enables bus-voltage-ok edge events
// (RQ5) bit 5 enables pin-floating edge events
// (RQ6) bit 4 enables resistor detector edge events
// (RQ7) bit 3: session-valid fall, alt_int set
// (RQ8) bit 2: session-valid rise, alt_int set
// (RQ9) session-valid edge enables default disabled
// (RQ10) bit 0 enables stress detector edge events
// (RQ11) set and clear aliases at 0x17, 0x18
`ifndef PSE_DEFS_SVH
`define PSE_DEFS_SVH
`define PSE_ADDR_SCRATCH     8'h16
`define PSE_ADDR_SCRATCH_SET 8'h17
`define PSE_ADDR_SCRATCH_CLR 8'h18
`define PSE_ADDR_PWR_CTRL    8'h3D
`define PSE_ADDR_IRQ_STATUS  8'h40
`define PSE_ADDR_IRQ_MASK    8'h41
`define PSE_RST_BYTE         8'h00
`define PSE_PWR_WMASK        8'h7D
`define PSE_BIT_VBUS_OK      6
`define PSE_BIT_OTG_PIN_FLOATING_DETECT     5
`define PSE_BIT_ID_RES       4
`define PSE_BIT_BSV_FALL     3
`define PSE_BIT_BSV_RISE     2
`define PSE_BIT_STRESS       0
`define PSE_SYNC_STAGES      2
`define PSE_EDGE_WARM        2'h3
`endif

// >>> pse_pkg.sv
// types shared by the scratch and power event register block
package pse_pkg;
  // event send state
  typedef enum logic [1:0]
  {
    PSE_IDLE = 2'b00,
    PSE_SEND = 2'b01
  } pse_state_e;
  typedef logic [7:0] pse_byte_t;
endpackage : pse_pkg

// >>> pse_sync.sv
// two-flop synchroniser for a vector of asynchronous monitor inputs
module pse_sync
#(
  parameter int W = 1
)
(
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         nrst_i,
  // data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  // state: first and second stage
  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pse_sync_s;
  pse_sync_s st_r;
  pse_sync_s st_nxt;
  // shift through both stages
  always_comb
  begin
    st_nxt.s1 = async_i;
    st_nxt.s2 = st_r.s1;
  end
  // register the stages
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign sync_o = st_r.s2;
endmodule : pse_sync

// >>> pse_edge.sv
// edge detector on synchronised monitor levels
`include "pse_defs.svh"
module pse_edge
#(
  parameter int W = 1
)
(
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         nrst_i,
  // levels in, edges out
  input  wire logic [W-1:0] level_i,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);
  // state: previous level and a warm-up count that hides the synchroniser reset value
  typedef struct packed
  {
    logic [W-1:0] prev;
    logic [1:0]   warm;
  } pse_edge_s;
  pse_edge_s st_r;
  pse_edge_s st_nxt;
  // track the last level
  always_comb
  begin
    st_nxt.prev = level_i;
    // stop counting once prev carries a real pin sample
    if (st_r.warm == `PSE_EDGE_WARM)
      st_nxt.warm = st_r.warm;
    else
      st_nxt.warm = st_r.warm + 2'h1;
  end
  // register
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  // edges only once prev holds a real sample, so a pin idling high gives no false edge
  assign rise_o = (st_r.warm == `PSE_EDGE_WARM) ? (level_i & ~st_r.prev) : '0;
  assign fall_o = (st_r.warm == `PSE_EDGE_WARM) ? (~level_i & st_r.prev) : '0;
endmodule : pse_edge

// >>> pse_regs.sv
// scratch and power event control registers with event notification
//
// The plain strobed port was decided locally.
`include "pse_defs.svh"
module pse_regs
  import pse_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  // register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // analogue monitor levels (asynchronous)
  input  wire logic       bus_voltage_ok_monitor_i,
  input  wire logic       otg_pin_floating_detect_i,
  input  wire logic       otg_resistor_detect_a_i,
  input  wire logic       otg_resistor_detect_b_i,
  input  wire logic       otg_resistor_detect_c_i,
  input  wire logic       session_valid_i,
  input  wire logic       stress_detect_i,
  // rx command request toward the link side
  output logic            rx_cmd_req_o,
  output logic            rx_cmd_alt_int_o,
  input  wire logic       rx_cmd_ack_i,
  // interrupt
  output logic            irq_o
);
  // monitor vector index: 0 vbus,1 float,2-4 res,5 bsv,6 stress
  localparam int NMON = 7;
  logic [NMON-1:0] mon_async;
  logic [NMON-1:0] mon_sync;
  logic [NMON-1:0] mon_rise;
  logic [NMON-1:0] mon_fall;
  // all block state
  typedef struct packed
  {
    pse_byte_t  scratch;
    pse_byte_t  pwr;
    pse_byte_t  irq_stat;
    pse_byte_t  irq_mask;
    pse_byte_t  rdata;
    pse_state_e state;
    logic       pend;
    logic       pend_alt;
    logic       alt;
  } pse_regs_s;
  pse_regs_s st_r;
  pse_regs_s st_nxt;
  logic       ev_any;
  logic       ev_alt;
  pse_byte_t  ev_vec;

  // address decode shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  assign mon_async = {stress_detect_i, session_valid_i, otg_resistor_detect_c_i,
                      otg_resistor_detect_b_i, otg_resistor_detect_a_i,
                      otg_pin_floating_detect_i, bus_voltage_ok_monitor_i};

  // synchronise the monitor pins
  pse_sync #(.W(NMON)) u_sync
  (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .async_i   (mon_async),
    .sync_o    (mon_sync)
  );

  // detect edges on the synchronised levels
  pse_edge #(.W(NMON)) u_edge
  (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .level_i   (mon_sync),
    .rise_o    (mon_rise),
    .fall_o    (mon_fall)
  );

  // gate edges with the enables
  always_comb
  begin
    ev_vec = 8'h00;
    // (RQ4) bus voltage ok edges
    ev_vec[`PSE_BIT_VBUS_OK]  = st_r.pwr[`PSE_BIT_VBUS_OK] & (mon_rise[0] | mon_fall[0]);
    // (RQ5) pin floating edges
    ev_vec[`PSE_BIT_OTG_PIN_FLOATING_DETECT] = st_r.pwr[`PSE_BIT_OTG_PIN_FLOATING_DETECT] & (mon_rise[1] | mon_fall[1]);
    // (RQ6) any resistor detector edge
    ev_vec[`PSE_BIT_ID_RES]   = st_r.pwr[`PSE_BIT_ID_RES] & (|(mon_rise[4:2] | mon_fall[4:2]));
    // (RQ7) session valid falling
    ev_vec[`PSE_BIT_BSV_FALL] = st_r.pwr[`PSE_BIT_BSV_FALL] & mon_fall[5];
    // (RQ8) session valid rising
    ev_vec[`PSE_BIT_BSV_RISE] = st_r.pwr[`PSE_BIT_BSV_RISE] & mon_rise[5];
    // (RQ10) stress detector edges
    ev_vec[`PSE_BIT_STRESS]   = st_r.pwr[`PSE_BIT_STRESS] & (mon_rise[6] | mon_fall[6]);
  end
  assign ev_any = |ev_vec;
  assign ev_alt = ev_vec[`PSE_BIT_BSV_FALL] | ev_vec[`PSE_BIT_BSV_RISE];

  // next state: registers, interrupt status, rx command sequencing
  always_comb
  begin
    st_nxt = st_r;
    // read data stands only in the cycle after the read strobe
    st_nxt.rdata = 8'h00;
    if (reg_rd_i)
    begin
      // (RQ11) aliases read back the scratch value
      if (hit(reg_addr_i, `PSE_ADDR_SCRATCH) || hit(reg_addr_i, `PSE_ADDR_SCRATCH_SET) ||
          hit(reg_addr_i, `PSE_ADDR_SCRATCH_CLR))
        st_nxt.rdata = st_r.scratch;
      else if (hit(reg_addr_i, `PSE_ADDR_PWR_CTRL))
        st_nxt.rdata = st_r.pwr;
      else if (hit(reg_addr_i, `PSE_ADDR_IRQ_STATUS))
        st_nxt.rdata = st_r.irq_stat;
      else if (hit(reg_addr_i, `PSE_ADDR_IRQ_MASK))
        st_nxt.rdata = st_r.irq_mask;
      // unmapped addresses read zero
      else
        st_nxt.rdata = 8'h00;
    end
    if (reg_wr_i)
    begin
      // (RQ1) plain scratch write
      if (hit(reg_addr_i, `PSE_ADDR_SCRATCH))
        st_nxt.scratch = reg_wdata_i;
      // (RQ11) set alias
      else if (hit(reg_addr_i, `PSE_ADDR_SCRATCH_SET))
        st_nxt.scratch = st_r.scratch | reg_wdata_i;
      // (RQ11) clear alias
      else if (hit(reg_addr_i, `PSE_ADDR_SCRATCH_CLR))
        st_nxt.scratch = st_r.scratch & ~reg_wdata_i;
      // (RQ3) spare bits held at zero
      else if (hit(reg_addr_i, `PSE_ADDR_PWR_CTRL))
        st_nxt.pwr = reg_wdata_i & `PSE_PWR_WMASK;
      else if (hit(reg_addr_i, `PSE_ADDR_IRQ_STATUS))
        st_nxt.irq_stat = st_r.irq_stat & ~reg_wdata_i;
      else if (hit(reg_addr_i, `PSE_ADDR_IRQ_MASK))
        st_nxt.irq_mask = reg_wdata_i;
    end
    // new events win over a same-cycle clear
    st_nxt.irq_stat = st_nxt.irq_stat | ev_vec;
    // collect events while a command is outstanding
    if (ev_any)
    begin
      st_nxt.pend     = 1'b1;
      st_nxt.pend_alt = st_nxt.pend_alt | ev_alt;
    end
    unique case (st_r.state)
      // launch a command when events wait
      PSE_IDLE:
      begin
        if (st_nxt.pend)
        begin
          st_nxt.state    = PSE_SEND;
          st_nxt.alt      = st_nxt.pend_alt;
          st_nxt.pend     = 1'b0;
          st_nxt.pend_alt = 1'b0;
        end
      end
      // hold the request until the link side takes it
      PSE_SEND:
      begin
        if (rx_cmd_ack_i)
        begin
          st_nxt.state = PSE_IDLE;
          st_nxt.alt   = 1'b0;
        end
      end
      default:
      begin
        st_nxt.state = PSE_IDLE;
      end
    endcase
  end

  // register all state
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      // (RQ9) all enables start disabled
      st_r          <= '0;
      st_r.scratch  <= `PSE_RST_BYTE;
      st_r.pwr      <= `PSE_RST_BYTE;
      st_r.irq_mask <= `PSE_RST_BYTE;
      st_r.state    <= PSE_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  // outputs; scratch only reaches the read mux
  // (RQ2) scratch is isolated
  assign reg_rdata_o      = st_r.rdata;
  assign rx_cmd_req_o     = (st_r.state == PSE_SEND);
  assign rx_cmd_alt_int_o = st_r.alt;
  assign irq_o            = |(st_r.irq_stat & st_r.irq_mask);


  // checks: every property samples on the system clock and sleeps in reset
  // alt_int is raised when a session-valid edge meets an idle sender
  sequence s_bsv_edge;
    ev_alt;
  endsequence
  // any enabled event while the sender is idle
  sequence s_idle_event;
    ev_any && st_r.state == PSE_IDLE;
  endsequence
  // an enabled event while a request still waits for the link
  sequence s_pend_event;
    ev_any && rx_cmd_req_o && !rx_cmd_ack_i;
  endsequence
  // the link takes a request while more events are already collected
  sequence s_handoff;
    rx_cmd_req_o && rx_cmd_ack_i && st_r.pend;
  endsequence
  // request drops for one cycle, then the collected events go out
  sequence s_rearm;
    !rx_cmd_req_o ##1 rx_cmd_req_o;
  endsequence

  // (RQ8) alt flag on edges
  a_alt_flag_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ8
    s_bsv_edge and (st_r.state == PSE_IDLE) |=> rx_cmd_req_o && rx_cmd_alt_int_o)
    else $error("alt_int not set for session valid edge");
  // (RQ4) bus voltage recorded
  a_vbus_event: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ4
    st_r.pwr[6] && (mon_rise[0] || mon_fall[0]) |=> st_r.irq_stat[6])
    else $error("bus voltage event not recorded");
  // (RQ6) resistor enable gates
  a_enable_gates: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ6
    !st_r.pwr[4] && !st_r.irq_stat[4] |=> !st_r.irq_stat[4])
    else $error("resistor event without enable");
  // (RQ3) spare bits low
  a_spare_zero: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ3
    st_r.pwr[7] == 1'b0 && st_r.pwr[1] == 1'b0)
    else $error("spare bits set");
  // (RQ11) set alias bits
  a_set_alias: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ11
    reg_wr_i && reg_addr_i == 8'h17 |=> st_r.scratch == ($past(st_r.scratch) | $past(reg_wdata_i)))
    else $error("set alias wrong");
  // (RQ11) clear alias bits
  a_clr_alias: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ11
    reg_wr_i && reg_addr_i == 8'h18 |=> st_r.scratch == ($past(st_r.scratch) & ~$past(reg_wdata_i)))
    else $error("clear alias wrong");
  // (RQ1) scratch read back
  a_scratch_read: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ1
    reg_rd_i && reg_addr_i == 8'h16 && !reg_wr_i |=> reg_rdata_o == $past(st_r.scratch))
    else $error("scratch readback wrong");
  // (RQ4) request held until taken
  a_req_holds: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ4
    rx_cmd_req_o && !rx_cmd_ack_i |=> rx_cmd_req_o)
    else $error("request dropped before ack");

  // per-source recording of enabled edges, and alt_int requests for session-valid edges
  // (RQ5) pin floating recorded
  a_float_event: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ5
    st_r.pwr[5] && (mon_rise[1] || mon_fall[1]) |=> st_r.irq_stat[5])
    else $error("pin floating event not recorded");
  // (RQ6) resistor edge recorded
  a_res_event: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ6
    st_r.pwr[4] && (|(mon_rise[4:2] | mon_fall[4:2])) |=> st_r.irq_stat[4])
    else $error("resistor event not recorded");
  // (RQ10) stress edge recorded
  a_stress_event: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ10
    st_r.pwr[0] && (mon_rise[6] || mon_fall[6]) |=> st_r.irq_stat[0])
    else $error("stress event not recorded");
  // (RQ7) falling session edge
  a_fall_alt_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ7
    st_r.pwr[3] && mon_fall[5] && st_r.state == PSE_IDLE |=> rx_cmd_req_o && rx_cmd_alt_int_o)
    else $error("session fall not sent with alt_int");
  // (RQ8) rising session edge
  a_rise_alt_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ8
    st_r.pwr[2] && mon_rise[5] && st_r.state == PSE_IDLE |=> rx_cmd_req_o && rx_cmd_alt_int_o)
    else $error("session rise not sent with alt_int");

  // a disabled source must never reach the status register
  // (RQ4) voltage enable gates
  a_vbus_gate: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ4
    !st_r.pwr[6] && !st_r.irq_stat[6] |=> !st_r.irq_stat[6])
    else $error("bus voltage event without enable");
  // (RQ5) floating enable gates
  a_float_gate: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ5
    !st_r.pwr[5] && !st_r.irq_stat[5] |=> !st_r.irq_stat[5])
    else $error("pin floating event without enable");
  // (RQ7) fall enable gates
  a_fall_gate: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ7
    !st_r.pwr[3] && !st_r.irq_stat[3] |=> !st_r.irq_stat[3])
    else $error("session fall event without enable");
  // (RQ8) rise enable gates
  a_rise_gate: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ8
    !st_r.pwr[2] && !st_r.irq_stat[2] |=> !st_r.irq_stat[2])
    else $error("session rise event without enable");
  // (RQ10) stress enable gates
  a_stress_gate: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ10
    !st_r.pwr[0] && !st_r.irq_stat[0] |=> !st_r.irq_stat[0])
    else $error("stress event without enable");

  // request sequencing toward the link, and status bit 6 holding until cleared
  // (RQ4) event starts a request
  a_event_request: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ4
    s_idle_event |=> rx_cmd_req_o)
    else $error("idle event did not start a request");
  // (RQ4) request drops after acceptance
  a_ack_drop: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ4
    rx_cmd_req_o && rx_cmd_ack_i |=> !rx_cmd_req_o)
    else $error("request stayed up after ack");
  // (RQ4) events merge while waiting
  a_pend_merge: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ4
    s_pend_event |=> rx_cmd_req_o && st_r.pend)
    else $error("event lost while request waits");
  // (RQ4) merged events sent next
  a_pend_reissue: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ4
    s_handoff |=> s_rearm)
    else $error("collected events not sent after ack");
  // (RQ7) alt only with a request
  a_alt_needs_req: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ7
    rx_cmd_alt_int_o |-> rx_cmd_req_o)
    else $error("alt_int without request");
  // (RQ4) status bit 6 stays until cleared
  a_status_sticky: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ4
    st_r.irq_stat[6] && !(reg_wr_i && reg_addr_i == 8'h40 && reg_wdata_i[6]) |=> st_r.irq_stat[6])
    else $error("status bit lost without clear");

  // register bus behaviour
  // (RQ1) scratch takes written byte
  a_scratch_write: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ1
    reg_wr_i && reg_addr_i == 8'h16 |=> st_r.scratch == $past(reg_wdata_i))
    else $error("scratch write lost");
  // (RQ1) scratch holds without writes
  a_scratch_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ1
    !(reg_wr_i && (reg_addr_i == 8'h16 || reg_addr_i == 8'h17 || reg_addr_i == 8'h18))
    |=> $stable(st_r.scratch))
    else $error("scratch changed without write");
  // (RQ11) aliases read back scratch
  a_alias_read: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ11
    reg_rd_i && (reg_addr_i == 8'h17 || reg_addr_i == 8'h18) |=> reg_rdata_o == $past(st_r.scratch))
    else $error("alias readback wrong");
  // (RQ1) read data idles at zero
  a_rdata_idle: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RQ1
    !reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data stands without read");
endmodule : pse_regs

// >>> pse_link_model.sv
// link-side partner that accepts rx command requests from the block
module pse_link_model
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  // request from the block
  input  wire logic       req_i,
  input  wire logic       alt_int_i,
  // idle cycles before accepting
  input  wire logic [3:0] delay_i,
  // answer and record
  output logic            ack_o,
  output logic      [7:0] n_cmd_o,
  output logic            alt_last_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_r;  // cycles spent on the current request
  // accept after delay_i cycles, count only when req is still up
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ack_o      <= 1'b0;
      wait_r     <= 4'h0;
      n_cmd_o    <= 8'h00;
      alt_last_o <= 1'b0;
    end
    else if (ack_o)
    begin
      // command taken at this edge, then one idle cycle
      ack_o <= 1'b0;
      if (req_i)
      begin
        n_cmd_o    <= n_cmd_o + 8'h01;
        alt_last_o <= alt_int_i;
      end
    end
    else if (req_i && wait_r >= delay_i)
    begin
      ack_o  <= 1'b1;
      wait_r <= 4'h0;
    end
    else if (req_i)
      wait_r <= wait_r + 4'h1;
  end
endmodule : pse_link_model

// >>> tb_pse_regs.sv
// self-checking bench for the scratch and power event registers
`include "pse_defs.svh"
module tb_pse_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_sys = 1'b0;  // 25 MHz system clock
  logic       nrst_n  = 1'b0;  // active low reset
  logic [7:0] addr    = 8'h00;
  logic [7:0] wdata   = 8'h00;
  logic       wr      = 1'b0;
  logic       rd      = 1'b0;
  logic [7:0] rdata;
  logic [6:0] mon     = 7'h00;  // 6 vbus,5 float,4..2 res a/b/c,1 session,0 stress
  logic       req, alt, ack, alt_last, irq;
  logic [3:0] delay   = 4'h0;
  logic [7:0] n_cmd;
  int         miscompares = 0;
  int         num_checks  = 0;
  always #20 clk_sys = ~clk_sys;
  pse_regs i_dut (.clk_sys_i(clk_sys), .nrst_i(nrst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .bus_voltage_ok_monitor_i(mon[6]),
    .otg_pin_floating_detect_i(mon[5]), .otg_resistor_detect_a_i(mon[4]),
    .otg_resistor_detect_b_i(mon[3]), .otg_resistor_detect_c_i(mon[2]), .session_valid_i(mon[1]),
    .stress_detect_i(mon[0]), .rx_cmd_req_o(req), .rx_cmd_alt_int_o(alt), .rx_cmd_ack_i(ack),
    .irq_o(irq));
  pse_link_model i_link (.clk_sys_i(clk_sys), .nrst_i(nrst_n), .req_i(req), .alt_int_i(alt),
    .delay_i(delay), .ack_o(ack), .n_cmd_o(n_cmd), .alt_last_o(alt_last));
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg
  // one-cycle read strobe, data judged in the following cycle
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    chk(rdata, exp);
  endtask : rd_reg
  // counts and verdict
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  // reset values of every register
  task automatic t_reset_values;
    rd_reg(`PSE_ADDR_SCRATCH, 8'h00);
    rd_reg(`PSE_ADDR_SCRATCH_SET, 8'h00);
    rd_reg(`PSE_ADDR_SCRATCH_CLR, 8'h00);
    rd_reg(`PSE_ADDR_PWR_CTRL, 8'h00);
    rd_reg(`PSE_ADDR_IRQ_STATUS, 8'h00);
    rd_reg(`PSE_ADDR_IRQ_MASK, 8'h00);
  endtask : t_reset_values
  // scratch write, set alias, clear alias, unmapped place
  task automatic t_scratch;
    wr_reg(`PSE_ADDR_SCRATCH, 8'hA5);
    rd_reg(`PSE_ADDR_SCRATCH, 8'hA5);
    wr_reg(`PSE_ADDR_SCRATCH_SET, 8'h0F);
    rd_reg(`PSE_ADDR_SCRATCH_SET, 8'hAF);
    wr_reg(`PSE_ADDR_SCRATCH_CLR, 8'h21);
    rd_reg(`PSE_ADDR_SCRATCH_CLR, 8'h8E);
    wr_reg(8'h55, 8'hFF);
    rd_reg(8'h55, 8'h00);
    rd_reg(`PSE_ADDR_SCRATCH, 8'h8E);
    chk(n_cmd, 8'h00);
    chk({7'h00, irq}, 8'h00);
  endtask : t_scratch
  // spare bits never written with ones
  task automatic t_pwr_ctrl;
    wr_reg(`PSE_ADDR_PWR_CTRL, 8'h7D);
    rd_reg(`PSE_ADDR_PWR_CTRL, 8'h7D);
  endtask : t_pwr_ctrl
  // move one monitor pin with given enable and mask, judge the outcome
  task automatic t_event(input int idx, input logic [7:0] en, input logic [7:0] msk,
                         input logic lvl, input logic fire, input logic exp_alt);
    logic [7:0] n0;
    n0 = n_cmd;
    wr_reg(`PSE_ADDR_PWR_CTRL, en);
    wr_reg(`PSE_ADDR_IRQ_MASK, msk);
    @(posedge clk_sys);
    mon[idx] <= lvl;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(n_cmd, n0 + {7'h00, fire});
    if (fire)
      chk({7'h00, alt_last}, {7'h00, exp_alt});
    chk({7'h00, irq}, {7'h00, fire && ((en & msk) != 8'h00)});
    rd_reg(`PSE_ADDR_IRQ_STATUS, fire ? en : 8'h00);
    wr_reg(`PSE_ADDR_IRQ_STATUS, 8'hFF);
    rd_reg(`PSE_ADDR_IRQ_STATUS, 8'h00);
    chk({7'h00, irq}, 8'h00);
  endtask : t_event
  // second event while a request waits: collected into one follow-up request
  task automatic t_merge;
    logic [7:0] n0;
    n0 = n_cmd;
    wr_reg(`PSE_ADDR_PWR_CTRL, 8'h60);
    wr_reg(`PSE_ADDR_IRQ_MASK, 8'h00);
    @(posedge clk_sys);
    mon[6] <= ~mon[6];
    repeat (2) @(posedge clk_sys);
    mon[5] <= ~mon[5];
    repeat (30) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(n_cmd, n0 + 8'h02);
    chk({7'h00, alt_last}, 8'h00);
    rd_reg(`PSE_ADDR_IRQ_STATUS, 8'h60);
    wr_reg(`PSE_ADDR_IRQ_STATUS, 8'hFF);
    rd_reg(`PSE_ADDR_IRQ_STATUS, 8'h00);
  endtask : t_merge
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk_sys);
    nrst_n <= 1'b1;
    t_reset_values();
    t_scratch();
    t_pwr_ctrl();
    t_event(6, 8'h40, 8'h40, 1, 1, 0);
    t_event(6, 8'h40, 8'h00, 0, 1, 0);
    t_event(5, 8'h20, 8'h20, 1, 1, 0);
    t_event(5, 8'h20, 8'h20, 0, 1, 0);
    t_event(4, 8'h10, 8'h10, 1, 1, 0);
    t_event(3, 8'h10, 8'h10, 1, 1, 0);
    t_event(2, 8'h10, 8'h10, 1, 1, 0);
    t_event(4, 8'h10, 8'h10, 0, 1, 0);
    delay <= 4'h6;
    t_event(1, 8'h04, 8'h04, 1, 1, 1);
    t_event(1, 8'h04, 8'h04, 0, 0, 0);
    t_event(1, 8'h08, 8'h08, 1, 0, 0);
    t_event(1, 8'h08, 8'h08, 0, 1, 1);
    t_merge();
    delay <= 4'h0;
    t_event(0, 8'h01, 8'h01, 1, 1, 0);
    t_event(0, 8'h01, 8'h01, 0, 1, 0);
    t_event(0, 8'h40, 8'h40, 1, 0, 0);
    t_event(6, 8'h00, 8'hFF, 0, 0, 0);
    give_verdict();
  end
endmodule : tb_pse_regs
